// ===== hdl/asr_seq.sv
`timescale 1ns/1ps
module asr_seq #(
    parameter int OUT_PERIOD_CYC = asr_pkg::OUT_PERIOD_DEF_CYC
) (
    // Clock and system reset
    input wire logic clock,
    input wire logic nrst,
    // Host control pins
    input wire logic syncPinN,
    input wire logic resetPinN,
    input wire logic filterSyncBit,
    input wire logic dataRead,
    // Clock forwarding
    output wire logic mclkOut,
    // Converter sequencing
    output wire logic filterRun,
    output wire logic modTick,
    output wire logic dataLoad,
    output wire logic syncStart,
    // Host status pin
    output wire logic wordReadyN
);

    typedef struct packed {
        logic syncPinR;
        logic syncPrev;
        logic resetPinR;
        logic filterRun;
        logic [1:0] settleCnt;
        asr_pkg::asr_rdy_e rdy;
        logic [8:0] pulseCnt;
        logic dataLoad;
        logic syncStart;
        logic wordReadyN;
    } asr_seq_s;

    asr_seq_s st_r;
    asr_seq_s st_nxt;

    asr_tick_if outTk ();
    asr_tick_if modTk ();

    logic hold;
    logic loadNow;
    logic readNow;

    // Output-rate divider; cleared while the filter is held
    asr_rate_tick #(
        .PERIOD(OUT_PERIOD_CYC)
    ) u_out_tick (
        .clock(clock),
        .nrst(nrst),
        .tk(outTk.cnt)
    );

    // Modulator strobe divider, aligned to the same release edge
    asr_rate_tick #(
        .PERIOD(asr_pkg::MOD_DIV_CYC)
    ) u_mod_tick (
        .clock(clock),
        .nrst(nrst),
        .tk(modTk.cnt)
    );

    // Both dividers restart together so every device on the same sync lines up
    assign outTk.clr = !st_r.filterRun;
    assign modTk.clr = !st_r.filterRun;

    // Forwarded master clock; no reset term so it never stops
    assign mclkOut = clock;
    // The reset pin is kept out of this path on purpose: a host clocked from
    // here must keep running through a reset command

    // Held by a low sync pin, a set sync bit or a low reset pin
    always_comb begin
        hold = !st_r.syncPinR || filterSyncBit || !st_r.resetPinR;
        readNow = dataRead && st_r.resetPinR;
        loadNow = st_r.filterRun && !hold && outTk.tick && (st_r.settleCnt >= asr_pkg::SETTLE_LAST);
    end

    // Next state of the sequencer
    always_comb begin
        st_nxt = st_r;
        st_nxt.syncPinR = syncPinN;
        st_nxt.syncPrev = st_r.syncPinR;
        st_nxt.resetPinR = resetPinN;
        st_nxt.dataLoad = 1'b0;
        // Rising sync, seen on consecutive samples, marks a start-convert
        st_nxt.syncStart = st_r.syncPinR && !st_r.syncPrev;

        // Filter and modulator run from the clock after the hold ends
        st_nxt.filterRun = !hold;

        // Settling counts whole output periods from the release
        if (hold || !st_r.filterRun) begin
            st_nxt.settleCnt = 2'h0;
        end else if (outTk.tick && st_r.settleCnt != asr_pkg::SETTLE_FULL) begin
            st_nxt.settleCnt = st_r.settleCnt + 2'h1;
        end

        if (loadNow) begin
            st_nxt.dataLoad = 1'b1;
        end

        // Word-ready tracking; a load in the same cycle as a read wins
        if (!st_r.resetPinR) begin
            st_nxt.rdy = asr_pkg::RDY_EMPTY;
            st_nxt.pulseCnt = 9'h000;
        end else if (loadNow && !readNow && st_r.rdy != asr_pkg::RDY_EMPTY) begin
            st_nxt.rdy = asr_pkg::RDY_GAP;
            st_nxt.pulseCnt = 9'h000;
        end else if (loadNow) begin
            st_nxt.rdy = asr_pkg::RDY_FULL;
            st_nxt.pulseCnt = 9'h000;
        end else if (readNow) begin
            st_nxt.rdy = asr_pkg::RDY_EMPTY;
            st_nxt.pulseCnt = 9'h000;
        end else begin
            // Sync alone leaves an unread word and an empty register as they are
            case (st_r.rdy)
                asr_pkg::RDY_GAP: begin
                    if (st_r.pulseCnt == asr_pkg::WR_PULSE_LAST) begin
                        st_nxt.rdy = asr_pkg::RDY_FULL;
                    end else begin
                        st_nxt.pulseCnt = st_r.pulseCnt + 9'h001;
                    end
                end
                asr_pkg::RDY_FULL: begin
                    st_nxt.rdy = asr_pkg::RDY_FULL;
                end
                default: begin
                    st_nxt.rdy = asr_pkg::RDY_EMPTY;
                end
            endcase
        end

        // Pin is low only while an unread word sits in the register
        st_nxt.wordReadyN = (st_nxt.rdy != asr_pkg::RDY_FULL);
    end

    // State register; pins sample high so nothing looks asserted after reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{
                syncPinR: 1'b1,
                syncPrev: 1'b1,
                resetPinR: 1'b1,
                filterRun: 1'b0,
                settleCnt: 2'h0,
                rdy: asr_pkg::RDY_EMPTY,
                pulseCnt: 9'h000,
                dataLoad: 1'b0,
                syncStart: 1'b0,
                wordReadyN: 1'b1
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign filterRun = st_r.filterRun;
    assign modTick = modTk.tick;
    assign dataLoad = st_r.dataLoad;
    assign syncStart = st_r.syncStart;
    assign wordReadyN = st_r.wordReadyN;

    // Helper counts for checks spanning long intervals
    int hiRun;
    int sinceRun;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hiRun <= 0;
            sinceRun <= 0;
        end else begin
            hiRun <= st_r.wordReadyN ? hiRun + 1 : 0;
            sinceRun <= !st_r.filterRun ? 0 : (sinceRun < 32'h3fffffff ? sinceRun + 1 : sinceRun);
        end
    end

    // All checks run on the master clock and sleep while the system reset is low
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_hold_stops_filter: assert property (hold |=> !filterRun)
        else $error("Filter ran while sync or reset held");

    a_release_resumes: assert property ($fell(hold) |-> filterRun == 1'b0 ##1 filterRun)
        else $error("Filter did not resume on the clock after release");

    a_reset_ready_high: assert property (!st_r.resetPinR |=> wordReadyN && !dataLoad)
        else $error("Word-ready not forced high under reset pin");

    a_read_sets_high: assert property ((readNow && !loadNow) |=> wordReadyN)
        else $error("Read did not return word-ready high");

    a_sync_keeps_low: assert property (
        (hold && st_r.resetPinR && !wordReadyN && !dataRead) |=> !wordReadyN)
        else $error("Sync disturbed an unread word");

    // An empty register stays empty under sync; a running gap still ends low, its word unread
    a_sync_keeps_high: assert property (
        (hold && wordReadyN && st_r.rdy == asr_pkg::RDY_EMPTY) |=> wordReadyN)
        else $error("Word-ready fell during sync hold");

    a_settle_first: assert property (dataLoad |-> sinceRun > asr_pkg::SETTLE_PERIODS * OUT_PERIOD_CYC)
        else $error("Word loaded before three output periods of settling");

    a_gap_start: assert property (
        (loadNow && !readNow && st_r.rdy == asr_pkg::RDY_FULL) |=> wordReadyN [*8])
        else $error("Update over unread word did not raise word-ready");

    a_gap_width: assert property (
        ($fell(wordReadyN) && $past(st_r.rdy) == asr_pkg::RDY_GAP)
        |-> hiRun >= asr_pkg::WR_PULSE_CYC)
        else $error("Word-ready gap shorter than 500 clocks");

    a_load_lowers: assert property (
        (dataLoad && $past(st_r.rdy) == asr_pkg::RDY_EMPTY) |-> !wordReadyN)
        else $error("Fresh word did not bring word-ready low");

    // A gap ends low again when no read or load lands on its last cycle
    a_gap_expires: assert property (
        (st_r.rdy == asr_pkg::RDY_GAP && st_r.pulseCnt == asr_pkg::WR_PULSE_LAST && !loadNow
        && !readNow && st_r.resetPinR) |=> !wordReadyN)
        else $error("Word-ready gap did not end low");

    // A new load during a gap restarts the full gap
    a_gap_restart: assert property (
        (loadNow && !readNow && st_r.rdy == asr_pkg::RDY_GAP)
        |=> st_r.rdy == asr_pkg::RDY_GAP && st_r.pulseCnt == 9'h000)
        else $error("Load during a gap did not restart it");

    // Sync release with an unread word leaves word-ready low
    a_release_low: assert property (
        ($fell(hold) && !wordReadyN && !readNow) |=> !wordReadyN)
        else $error("Sync release raised word-ready over an unread word");

    // Nothing lowers word-ready from an empty register except a fresh word
    a_ready_empty: assert property (
        (st_r.rdy == asr_pkg::RDY_EMPTY && !loadNow) |=> wordReadyN)
        else $error("Word-ready fell with no new word");

    // A rising sync sample gives a start pulse on the next edge
    a_start_edge: assert property ($rose(st_r.syncPinR) |=> syncStart)
        else $error("Sync rising edge gave no start pulse");

    // The start pulse is one cycle wide
    a_start_once: assert property (syncStart |=> !syncStart)
        else $error("Start pulse longer than one cycle");

    // Pins are plain registered samples of the previous edge
    a_pin_sample: assert property (
        $past(nrst) |-> st_r.syncPinR == $past(syncPinN) && st_r.resetPinR == $past(resetPinN))
        else $error("Pin sample does not match the previous edge");

    // Reset pin holds the filter and clears settling
    a_pin_reset_hold: assert property (
        !st_r.resetPinR |=> !filterRun && st_r.settleCnt == 2'h0)
        else $error("Filter left running under the reset pin");

    // Sync or reset hold discards all settling done so far
    a_settle_reset: assert property (hold |=> st_r.settleCnt == 2'h0)
        else $error("Settling count kept through a hold");

    // No word is loaded while the filter is held
    a_held_no_load: assert property (hold |=> !dataLoad)
        else $error("Word loaded while the filter was held");

    // Loads are single pulses
    a_load_pulse: assert property (dataLoad |=> !dataLoad)
        else $error("Load pulse longer than one cycle");

    // Loads only ever come from a running filter
    a_load_running: assert property (dataLoad |-> filterRun)
        else $error("Word loaded with the filter stopped");

    // Just after a release the filter is still settling; six cycles hold for any period of two up
    a_wait_first: assert property ($rose(filterRun) |=> !dataLoad [*6])
        else $error("Word loaded straight after a release");

    // Modulator strobe is silent once the filter has been held for a cycle
    a_mod_quiet: assert property ((!filterRun ##1 !filterRun) |-> !modTick)
        else $error("Modulator strobe ran while held");

    // Strobes are far apart; eight quiet cycles are enough to catch a stuck divider
    a_mod_single: assert property (modTick |=> !modTick [*8])
        else $error("Modulator strobe repeated too soon");

endmodule // asr_seq

// ===== hdl/asr_pkg.sv
package asr_pkg;

    // Clock figures
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_FREQ_HZ = 1000000000 / CLK_PERIOD_NS;

    // Modulator strobe: one modulator cycle is this many master clocks
    localparam int MOD_DIV_CYC = 128;

    // Default output-rate period in master clocks; the real figure is set by the filter word
    localparam int OUT_PERIOD_DEF_CYC = 12800;

    // Filter settling after a sync or reset release, in output-rate periods
    localparam int SETTLE_PERIODS = 3;
    localparam logic [1:0] SETTLE_LAST = 2'h2;
    localparam logic [1:0] SETTLE_FULL = 2'h3;

    // Word-ready high gap on an update over an unread word, in master clock periods
    localparam int WR_PULSE_TCLK = 500;
    localparam int WR_PULSE_CYC = WR_PULSE_TCLK;
    localparam logic [8:0] WR_PULSE_LAST = 9'(WR_PULSE_CYC - 1);

    // Typical oscillator start-up the host waits for, in ms, per supply voltage
    localparam int OSC_START_5V_MS = 10;
    localparam int OSC_START_3V_MS = 15;

    // Word-ready states
    typedef enum logic [1:0] {
        RDY_EMPTY,
        RDY_FULL,
        RDY_GAP
    } asr_rdy_e;

endpackage

// ===== hdl/asr_tick_if.sv
`timescale 1ns/1ps
interface asr_tick_if;
    logic clr;
    logic tick;

    // Sequencer holds the divider in clear and takes its strobe
    modport ctl (output clr, input tick);
    // Divider side
    modport cnt (input clr, output tick);
endinterface

// ===== hdl/asr_rate_tick.sv
`timescale 1ns/1ps
module asr_rate_tick #(
    parameter int PERIOD = 128
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Strobe link to the sequencer
    asr_tick_if.cnt tk
);

    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] CNT_LAST = CW'(PERIOD - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } asr_tick_s;

    asr_tick_s st_r;
    asr_tick_s st_nxt;

    // Count master clocks; the strobe is one cycle wide every PERIOD cycles
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (tk.clr) begin
            st_nxt.cnt = CNT_ZERO;
        end else if (st_r.cnt == CNT_LAST) begin
            st_nxt.cnt = CNT_ZERO;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tk.tick = st_r.tick;

    // Strobe never repeats on back-to-back cycles for any period above one
    a_tick_gap: assert property (@(posedge clock) disable iff (!nrst)
        (st_r.tick && PERIOD > 1) |=> !st_r.tick)
        else $error("Rate strobe repeated on consecutive cycles");

endmodule // asr_rate_tick

// ===== tb/asr_host_model.sv
`timescale 1ns/1ps
module asr_host_model (
    // Clock
    input wire logic clock,
    // Control pins towards the converter
    output logic syncPinN,
    output logic resetPinN,
    output logic filterSyncBit,
    output logic dataRead
);
    // External clock feeds the part, so no oscillator start-up wait is needed
    initial begin
        syncPinN = 1'b1;
        resetPinN = 1'b1;
        filterSyncBit = 1'b0;
        dataRead = 1'b0;
    end

    // Pins move just after an edge; no background calibration, so sync is always allowed
    task automatic drive(input logic s, input logic r, input logic b);
        @(posedge clock);
        #2;
        syncPinN = s;
        resetPinN = r;
        filterSyncBit = b;
    endtask

    // One-cycle read strobe of the data word
    task automatic readWord();
        @(posedge clock);
        #2;
        dataRead = 1'b1;
        @(posedge clock);
        #2;
        dataRead = 1'b0;
    endtask
endmodule // asr_host_model

// ===== tb/asr_seq_tb.sv
`timescale 1ns/1ps
module asr_seq_tb;
    // Short output period keeps settling waits cheap
    localparam int P = 8;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    int cyc = 0;
    int err_total = 0;
    int n_checks = 0;
    int k;
    int loadQ[$];
    logic syncPinN, resetPinN, filterSyncBit, dataRead;
    logic mclkOut, filterRun, modTick, dataLoad, syncStart, wordReadyN;

    // Clock and edge counter
    always #12.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    asr_host_model asr_host_model_i (.clock(clock), .syncPinN(syncPinN),
        .resetPinN(resetPinN), .filterSyncBit(filterSyncBit), .dataRead(dataRead));
    asr_seq #(.OUT_PERIOD_CYC(P)) asr_seq_i (.clock(clock), .nrst(nrst),
        .syncPinN(syncPinN), .resetPinN(resetPinN), .filterSyncBit(filterSyncBit),
        .dataRead(dataRead), .mclkOut(mclkOut), .filterRun(filterRun), .modTick(modTick),
        .dataLoad(dataLoad), .syncStart(syncStart), .wordReadyN(wordReadyN));

    // Level compare; an unknown never matches
    task automatic chkLvl(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Load-edge compare
    task automatic chkCyc(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitTo(input int n);
        while (cyc < n) begin
            @(posedge clock);
            #2;
        end
    endtask

    // Note n loads one period apart, the first at edge e
    task automatic expLoads(input int e, input int n);
        for (int i = 0; i < n; i++) loadQ.push_back(e + i * P);
    endtask

    // Every load takes the oldest note; a load with no note is a mismatch
    always @(posedge clock) begin
        #1;
        if (dataLoad === 1'b1) begin
            if (loadQ.size() == 0) chkCyc(cyc, 32'hffffffff);
            else chkCyc(cyc, loadQ.pop_front());
        end
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Run is about 1300 edges; cut a hang well beyond that
    initial begin
        #(3000 * 25);
        err_total++;
        summarize();
    end

    initial begin
        void'($urandom(45));
        repeat (8) @(posedge clock);
        #1;
        chkLvl(wordReadyN, 1'b1);
        chkLvl(filterRun, 1'b0);
        chkLvl(mclkOut, clock);
        #1;
        nrst = 1'b1;
        k = cyc;
        expLoads(k + 2 + 3 * P, 3);
        waitTo(k + 1);
        chkLvl(filterRun, 1'b1);
        waitTo(k + 2 + 3 * P);
        chkLvl(wordReadyN, 1'b0);
        waitTo(k + 2 + 4 * P);
        chkLvl(wordReadyN, 1'b1);
        waitTo(k + 2 + 5 * P);
        k = k + 2 + 5 * P;
        asr_host_model_i.drive(1'b0, 1'b1, 1'b0);
        waitTo(k + 3);
        chkLvl(filterRun, 1'b0);
        waitTo(k + 499);
        chkLvl(wordReadyN, 1'b1);
        waitTo(k + 500);
        chkLvl(wordReadyN, 1'b0);
        $display("test reset_release done");
        // Reset pin forces word-ready high; settling restarts on release
        asr_host_model_i.drive(1'b0, 1'b0, 1'b0);
        k = cyc;
        waitTo(k + 2);
        chkLvl(wordReadyN, 1'b1);
        // Reset pin released; the block keeps no setup registers for the host to rewrite
        asr_host_model_i.drive(1'b0, 1'b1, 1'b0);
        repeat ($urandom_range(1, 8)) @(posedge clock);
        asr_host_model_i.drive(1'b1, 1'b1, 1'b0);
        k = cyc;
        expLoads(k + 3 + 3 * P, 2);
        waitTo(k + 2);
        chkLvl(syncStart, 1'b1);
        waitTo(k + 3 + 3 * P);
        chkLvl(wordReadyN, 1'b0);
        waitTo(k + 3 + 4 * P);
        chkLvl(wordReadyN, 1'b1);
        k = k + 3 + 4 * P;
        asr_host_model_i.drive(1'b0, 1'b1, 1'b0);
        waitTo(k + 500);
        chkLvl(wordReadyN, 1'b0);
        $display("test reset_pin done");
        // Sync release over an unread word, then a read during settling
        repeat ($urandom_range(1, 6)) @(posedge clock);
        asr_host_model_i.drive(1'b1, 1'b1, 1'b0);
        k = cyc;
        expLoads(k + 3 + 3 * P, 2);
        waitTo(k + 2);
        chkLvl(syncStart, 1'b1);
        chkLvl(wordReadyN, 1'b0);
        asr_host_model_i.readWord();
        chkLvl(wordReadyN, 1'b1);
        waitTo(k + 2 + 3 * P);
        chkLvl(wordReadyN, 1'b1);
        waitTo(k + 3 + 3 * P);
        chkLvl(wordReadyN, 1'b0);
        waitTo(k + 3 + 4 * P);
        chkLvl(wordReadyN, 1'b1);
        $display("test sync_unread done");
        // Sync bit holds and releases the filter one edge after it changes
        asr_host_model_i.drive(1'b1, 1'b1, 1'b1);
        k = cyc;
        waitTo(k + 1);
        chkLvl(filterRun, 1'b0);
        repeat ($urandom_range(2, 9)) @(posedge clock);
        asr_host_model_i.drive(1'b1, 1'b1, 1'b0);
        k = cyc;
        // Run long enough for one modulator strobe; loads stop once the bit is set again
        expLoads(k + 2 + 3 * P, (asr_pkg::MOD_DIV_CYC + 1) / P - 2);
        waitTo(k + 1);
        chkLvl(filterRun, 1'b1);
        waitTo(k + 2 + 3 * P);
        chkLvl(wordReadyN, 1'b1);
        waitTo(k + 1 + asr_pkg::MOD_DIV_CYC);
        chkLvl(modTick, 1'b1);
        waitTo(k + 2 + asr_pkg::MOD_DIV_CYC);
        chkLvl(modTick, 1'b0);
        asr_host_model_i.drive(1'b1, 1'b1, 1'b1);
        waitTo(cyc + 4 * P);
        chkCyc(loadQ.size(), 0);
        $display("test sync_bit done");
        summarize();
    end
endmodule // asr_seq_tb
